// *** verilog/mdh_consts.svh ***
`ifndef MDH_CONSTS_SVH
`define MDH_CONSTS_SVH

// Register byte addresses on the bus.
`define MDH_ADDR_CMD        12'h000
`define MDH_ADDR_ACCUM      12'h004
`define MDH_ADDR_STAT       12'h008
`define MDH_ADDR_CTRL       12'h00C
`define MDH_ADDR_WATCHDOG   12'h010
`define MDH_MEM_PAGE        4'h1

// Command word fields.
`define MDH_CMD_OP_LSB      8
`define MDH_CMD_IDX_MSB     7

// Status register bit positions.
`define MDH_STAT_ZERO       0
`define MDH_STAT_POWER_DOWN 1
`define MDH_STAT_TIMEOUT    2
`define MDH_STAT_HALTED     3

// Control register.
`define MDH_CTRL_WD_EN      0
`define MDH_CTRL_RST        1'b1

// Arithmetic step and reset values.
`define MDH_STEP            8'h01
`define MDH_BYTE_RST        8'h00

// Timing counts and memory depth.
`define MDH_PRE_DIV_DEF     256
`define MDH_WD_BITS_DEF     8
`define MDH_MEM_DEPTH_DEF   64

`endif

// *** verilog/mdh_pkg.sv ***
package mdh_pkg;

    typedef enum logic [1:0] {
        MDH_OP_NONE     = 2'h0,
        MDH_OP_DEC_ACCU = 2'h1,
        MDH_OP_INC      = 2'h2,
        MDH_OP_HALT     = 2'h3
    } mdh_op_t;

    typedef enum logic [1:0] {
        MDH_ST_RUN  = 2'b01,
        MDH_ST_HALT = 2'b10
    } mdh_state_t;

    typedef struct packed {
        logic halted;
        logic watchdog_timeout_status_flag;
        logic power_down_status_flag;
        logic zero;
    } mdh_flags_t;

endpackage

// *** verilog/mdh_alu.sv ***
`timescale 1ns/10ps
module mdh_alu (
    // Operation select
    input  wire mdh_pkg::mdh_op_t op_i,
    // Operand and result
    input  wire logic [7:0]       operand_i,
    output logic      [7:0]       result_o,
    output logic                  zero_o
);
`include "mdh_consts.svh"

    // Eight-bit arithmetic wraps by construction.
    always_comb begin
        if (op_i == mdh_pkg::MDH_OP_INC) begin
            result_o = operand_i + `MDH_STEP;
        end else begin
            result_o = operand_i - `MDH_STEP;
        end
        zero_o = (result_o == `MDH_BYTE_RST);
    end

endmodule

// *** verilog/mdh_exec_top.sv ***
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "mdh_consts.svh"
module mdh_exec_top #(
    parameter int MEM_DEPTH = `MDH_MEM_DEPTH_DEF,
    parameter int PRE_DIV   = `MDH_PRE_DIV_DEF,
    parameter int WD_BITS   = `MDH_WD_BITS_DEF
) (
    // Clock, reset, enable
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [11:0]         wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Wake-up pin
    input  wire logic                wake_pin_i,
    // Core status
    output logic                     sys_clk_en_o,
    output mdh_pkg::mdh_flags_t      flags_o,
    output logic      [7:0]          accumulator_o
);

    localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
    localparam int PRE_W = (PRE_DIV > 1) ? $clog2(PRE_DIV) : 1;

    // The memory window holds 64 words and the count reads back in 16 bits.
    if (MEM_DEPTH < 1 || MEM_DEPTH > 64 || PRE_DIV < 2 || WD_BITS < 1 || WD_BITS > 16) begin : g_chk
        $error("mdh_exec_top: unsupported parameter values");
    end

    mdh_pkg::mdh_state_t state;
    logic [7:0]         mem [MEM_DEPTH];
    logic [7:0]         accumulator_reg;
    logic               zero_flag;
    logic               power_down_status_flag;
    logic               watchdog_timeout_status_flag;
    logic               wd_en;
    logic [PRE_W-1:0]   pre_cnt;
    logic [WD_BITS-1:0] watchdog_timer;
    logic [2:0]         wake_sync;
    logic               access;
    logic               wr;
    logic               is_mem;
    logic [IDX_W-1:0]   bus_idx;
    logic [IDX_W-1:0]   cmd_idx;
    logic               cmd_ok;
    mdh_pkg::mdh_op_t   cmd_op;
    logic               exec_go;
    logic [7:0]         operand;
    logic [7:0]         alu_result;
    logic               alu_zero;
    logic               pre_tick;
    logic               wd_over;
    logic               wake;
    logic [31:0]        next_rdata;
    logic [IDX_W-1:0]   chk_idx;
    logic [7:0]         chk_val;

    assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr      = access && wb_we_i && wb_sel_i[0];
    assign is_mem  = (wb_adr_i[11:8] == `MDH_MEM_PAGE) && (32'(wb_adr_i[7:2]) < MEM_DEPTH);
    assign bus_idx = wb_adr_i[2 +: IDX_W];
    assign cmd_idx = wb_dat_i[IDX_W-1:0];
    assign cmd_ok  = 32'(wb_dat_i[`MDH_CMD_IDX_MSB:0]) < MEM_DEPTH;
    assign cmd_op  = mdh_pkg::mdh_op_t'(wb_dat_i[`MDH_CMD_OP_LSB +: 2]);
    // A command is taken only while running, so a halted core executes nothing.
    assign exec_go = ce_i && wr && wb_sel_i[1] && (wb_adr_i == `MDH_ADDR_CMD)
                     && (state == mdh_pkg::MDH_ST_RUN)
                     && (cmd_ok || cmd_op == mdh_pkg::MDH_OP_HALT);
    assign operand = mem[cmd_idx];
    assign pre_tick = (pre_cnt == PRE_W'(PRE_DIV - 1));
    assign wd_over  = pre_tick && (&watchdog_timer);
    // Only the second and third stages of the wake synchroniser are compared.
    assign wake     = wake_sync[1] && wake_sync[2];

    mdh_alu u_alu (
        .op_i      (cmd_op),
        .operand_i (operand),
        .result_o  (alu_result),
        .zero_o    (alu_zero)
    );

    // Data memory; every entry is one flip-flop byte.
    for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mem[g] <= `MDH_BYTE_RST;
            end else if (ce_i) begin
                if (exec_go && cmd_op == mdh_pkg::MDH_OP_INC && cmd_idx == IDX_W'(g)) begin
                    mem[g] <= alu_result;
                end else if (wr && is_mem && bus_idx == IDX_W'(g)
                             && state == mdh_pkg::MDH_ST_RUN) begin
                    mem[g] <= wb_dat_i[7:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accumulator_reg <= `MDH_BYTE_RST;
        end else if (ce_i) begin
            if (exec_go && cmd_op == mdh_pkg::MDH_OP_DEC_ACCU) begin
                accumulator_reg <= alu_result;
            end else if (wr && wb_adr_i == `MDH_ADDR_ACCUM && state == mdh_pkg::MDH_ST_RUN) begin
                accumulator_reg <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_flag <= 1'b0;
        end else if (exec_go && (cmd_op == mdh_pkg::MDH_OP_DEC_ACCU
                                 || cmd_op == mdh_pkg::MDH_OP_INC)) begin
            zero_flag <= alu_zero;
        end
    end

    // Halting drops the clock enable and clears the watchdog and its time-out flag; the accumulator and memory survive.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state        <= mdh_pkg::MDH_ST_RUN;
            sys_clk_en_o <= 1'b1;
        end else if (ce_i) begin
            case (state)
                mdh_pkg::MDH_ST_RUN: begin
                    if (exec_go && cmd_op == mdh_pkg::MDH_OP_HALT) begin
                        state        <= mdh_pkg::MDH_ST_HALT;
                        sys_clk_en_o <= 1'b0;
                    end
                end
                mdh_pkg::MDH_ST_HALT: begin
                    if (wake) begin
                        state        <= mdh_pkg::MDH_ST_RUN;
                        sys_clk_en_o <= 1'b1;
                    end
                end
                default: begin
                    state        <= mdh_pkg::MDH_ST_RUN;
                    sys_clk_en_o <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_sync <= 3'h0;
        end else if (ce_i) begin
            wake_sync <= {wake_sync[1:0], wake_pin_i};
        end
    end

    // The watchdog only runs while the core runs, as its count is enabled only in the run state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt        <= '0;
            watchdog_timer <= '0;
        end else if (ce_i) begin
            if (exec_go && cmd_op == mdh_pkg::MDH_OP_HALT) begin
                pre_cnt        <= '0;
                watchdog_timer <= '0;
            end else if (wd_en && state == mdh_pkg::MDH_ST_RUN) begin
                pre_cnt <= pre_tick ? '0 : pre_cnt + PRE_W'(1);
                if (pre_tick) begin
                    watchdog_timer <= watchdog_timer + WD_BITS'(1);
                end
            end
        end
    end

    // Flags: a hardware set beats a software write-one-to-clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_status_flag       <= 1'b0;
            watchdog_timeout_status_flag <= 1'b0;
        end else if (ce_i) begin
            if (exec_go && cmd_op == mdh_pkg::MDH_OP_HALT) begin
                power_down_status_flag       <= 1'b1;
                watchdog_timeout_status_flag <= 1'b0;
            end else begin
                if (wr && wb_adr_i == `MDH_ADDR_STAT && wb_dat_i[`MDH_STAT_POWER_DOWN]) begin
                    power_down_status_flag <= 1'b0;
                end
                if (wd_over && wd_en && state == mdh_pkg::MDH_ST_RUN) begin
                    watchdog_timeout_status_flag <= 1'b1;
                end else if (wr && wb_adr_i == `MDH_ADDR_STAT && wb_dat_i[`MDH_STAT_TIMEOUT]) begin
                    watchdog_timeout_status_flag <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_en <= `MDH_CTRL_RST;
        end else if (ce_i && wr && wb_adr_i == `MDH_ADDR_CTRL) begin
            wd_en <= wb_dat_i[`MDH_CTRL_WD_EN];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_mem) begin
            next_rdata = 32'(mem[bus_idx]);
        end else begin
            case (wb_adr_i)
                `MDH_ADDR_ACCUM:    next_rdata = 32'(accumulator_reg);
                `MDH_ADDR_STAT:     next_rdata = 32'({state == mdh_pkg::MDH_ST_HALT,
                                                     watchdog_timeout_status_flag,
                                                     power_down_status_flag, zero_flag});
                `MDH_ADDR_CTRL:     next_rdata = 32'(wd_en);
                `MDH_ADDR_WATCHDOG: next_rdata = 32'(watchdog_timer);
                default:            next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o       <= '0;
            accumulator_o <= `MDH_BYTE_RST;
        end else begin
            flags_o       <= {state == mdh_pkg::MDH_ST_HALT, watchdog_timeout_status_flag,
                              power_down_status_flag, zero_flag};
            accumulator_o <= accumulator_reg;
        end
    end

    // Helper capture of the operand for the checks below.
    always_ff @(posedge clk_i) begin
        chk_idx <= cmd_idx;
        chk_val <= operand;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DEC_LOADS_ACCUM: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_DEC_ACCU |=> accumulator_reg == 8'(chk_val - 8'h01)
    ) else $error("decrement did not load the accumulator");
    AST_DEC_KEEPS_MEM: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_DEC_ACCU |=> mem[chk_idx] == chk_val
    ) else $error("decrement changed the memory byte");
    AST_INC_IN_PLACE: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_INC |=> mem[chk_idx] == 8'(chk_val + 8'h01)
    ) else $error("increment did not write back");
    AST_HALT_STOPS_CLOCK: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_HALT |=> !sys_clk_en_o ##1 flags_o.halted
    ) else $error("halt did not stop the clock");
    AST_HALT_KEEPS_STATE: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_HALT
        |=> accumulator_reg == $past(accumulator_reg) && mem[chk_idx] == chk_val
    ) else $error("halt disturbed stored state");
    AST_HALT_CLEARS_WATCHDOG: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_HALT |=> watchdog_timer == '0 && pre_cnt == '0
    ) else $error("halt did not clear the watchdog");
    AST_HALT_FLAGS: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_HALT
        |=> power_down_status_flag && !watchdog_timeout_status_flag && $stable(zero_flag)
    ) else $error("halt flag update wrong");
    AST_ZERO_FLAG: assert property (
        exec_go && cmd_op == mdh_pkg::MDH_OP_INC |=> zero_flag == (mem[chk_idx] == 8'h00)
    ) else $error("zero flag does not match result");
    AST_HALTED_FROZEN: assert property (
        state == mdh_pkg::MDH_ST_HALT && !wake
        |=> $stable(accumulator_reg) && $stable(watchdog_timer)
    ) else $error("state moved while halted");

endmodule

// *** testbench/test_mdh_exec_top.sv ***
`timescale 1ns/10ps
`include "mdh_consts.svh"
module test_mdh_exec_top;
    logic                clk_i         = 1'b0;
    logic                rst_i         = 1'b1;
    logic                ce_i          = 1'b1;
    logic                wb_cyc_i      = 1'b0;
    logic                wb_stb_i      = 1'b0;
    logic                wb_we_i       = 1'b0;
    logic [11:0]         wb_adr_i      = 12'h000;
    logic [3:0]          wb_sel_i      = 4'hF;
    logic [31:0]         wb_dat_i      = 32'h00000000;
    logic                wake_pin_i    = 1'b0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    logic                sys_clk_en_o;
    mdh_pkg::mdh_flags_t flags_o;
    logic [7:0]          accumulator_o;
    int                  err_total     = 0;
    int                  compares      = 0;
    int                  seed          = 4842;
    int                  n;
    logic [31:0]         exp_q[$];
    logic [31:0]         exp_v;
    logic [7:0]          val;
    logic [7:0]          acc;
    logic [7:0]          nv;
    logic                zf;

    always #50 clk_i = ~clk_i;

    mdh_exec_top #(.MEM_DEPTH(64), .PRE_DIV(4), .WD_BITS(2)) dut (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .wb_cyc_i      (wb_cyc_i),
        .wb_stb_i      (wb_stb_i),
        .wb_we_i       (wb_we_i),
        .wb_adr_i      (wb_adr_i),
        .wb_sel_i      (wb_sel_i),
        .wb_dat_i      (wb_dat_i),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o),
        .wake_pin_i    (wake_pin_i),
        .sys_clk_en_o  (sys_clk_en_o),
        .flags_o       (flags_o),
        .accumulator_o (accumulator_o)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The request stands until the rising edge at which ack is sampled high, then it is released.
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        k = 0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            k++;
            if (k > 50) begin
                err_total++;
                end_sim();
            end
            @(posedge clk_i);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, 32'h00000000);
    endtask

    task automatic cmd(input mdh_pkg::mdh_op_t op, input logic [7:0] idx);
        bus(1'b1, `MDH_ADDR_CMD, {22'h000000, op, idx});
    endtask

    function automatic logic [11:0] madr(input int i);
        return {`MDH_MEM_PAGE, 6'(i), 2'b00};
    endfunction

    function automatic logic [31:0] st(input logic h, input logic t, input logic p, input logic z);
        return {28'h0000000, h, t, p, z};
    endfunction

    // Read data is taken at the edge where ack is sampled high; a read with no note fails.
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~wb_dat_o;
            check("read data", wb_dat_o, exp_v);
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`MDH_ADDR_STAT, st(1'b0, 1'b0, 1'b0, 1'b0));
        rd(`MDH_ADDR_CTRL, 32'h00000001);
        rd(12'h0FC, 32'h00000000);
        // The watchdog is held off so that the time-out flag stays predictable.
        bus(1'b1, `MDH_ADDR_CTRL, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            val = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($random(seed));
            bus(1'b1, madr(i), {24'h000000, val});
            cmd(mdh_pkg::MDH_OP_DEC_ACCU, 8'(i));
            acc = val - 8'h01;
            rd(`MDH_ADDR_ACCUM, {24'h000000, acc});
            rd(madr(i), {24'h000000, val});
            rd(`MDH_ADDR_STAT, st(1'b0, 1'b0, 1'b0, acc == 8'h00));
            cmd(mdh_pkg::MDH_OP_INC, 8'(i));
            nv = val + 8'h01;
            zf = (nv == 8'h00);
            rd(madr(i), {24'h000000, nv});
            rd(`MDH_ADDR_ACCUM, {24'h000000, acc});
            rd(`MDH_ADDR_STAT, st(1'b0, 1'b0, 1'b0, zf));
        end
        bus(1'b1, `MDH_ADDR_CTRL, 32'h00000001);
        repeat (40) @(posedge clk_i);
        rd(`MDH_ADDR_STAT, st(1'b0, 1'b1, 1'b0, zf));
        bus(1'b1, `MDH_ADDR_ACCUM, 32'h0000005A);
        check("clock enable", {31'h0, sys_clk_en_o}, 32'h00000001);
        cmd(mdh_pkg::MDH_OP_HALT, 8'h00);
        repeat (2) @(negedge clk_i);
        check("clock enable", {31'h0, sys_clk_en_o}, 32'h00000000);
        check("flags out", {28'h0000000, flags_o}, st(1'b1, 1'b0, 1'b1, zf));
        rd(`MDH_ADDR_STAT, st(1'b1, 1'b0, 1'b1, zf));
        repeat (10) @(posedge clk_i);
        rd(`MDH_ADDR_WATCHDOG, 32'h00000000);
        cmd(mdh_pkg::MDH_OP_INC, 8'h00);
        bus(1'b1, `MDH_ADDR_ACCUM, 32'h000000A5);
        bus(1'b1, madr(0), 32'h00000033);
        rd(`MDH_ADDR_ACCUM, 32'h0000005A);
        rd(madr(0), 32'h00000002);
        @(posedge clk_i);
        wake_pin_i <= 1'b1;
        n = 0;
        @(negedge clk_i);
        while (sys_clk_en_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                end_sim();
            end
            @(negedge clk_i);
        end
        @(posedge clk_i);
        wake_pin_i <= 1'b0;
        // The watchdog ran up to the halt; it is stopped now, long before it could time out.
        bus(1'b1, `MDH_ADDR_CTRL, 32'h00000000);
        rd(`MDH_ADDR_STAT, st(1'b0, 1'b0, 1'b1, zf));
        bus(1'b1, `MDH_ADDR_STAT, 32'h00000002);
        rd(`MDH_ADDR_STAT, st(1'b0, 1'b0, 1'b0, zf));
        cmd(mdh_pkg::MDH_OP_DEC_ACCU, 8'h00);
        rd(`MDH_ADDR_ACCUM, 32'h00000001);
        check("accumulator out", {24'h000000, accumulator_o}, 32'h00000001);
        end_sim();
    end
endmodule
